// [verilog/psp_port.sv]
// Parallel slave port: CPU register port plus the outside 8-bit bus.
// Assumes outside strobes are asynchronous and get synchronised here.
//
// Design decision made here: the address-and-strobe port.
`timescale 1ns/1ps
module psp_port (
   input  wire logic                     i_clk,
   input  wire logic                     i_arst_n,
   input  wire psp_pkg::psp_req_t        i_req,
   output logic [psp_pkg::DATA_W-1:0]    o_rdata,
   input  wire logic [7:0]               i_pd_in,
   output logic [7:0]                    o_pd_out,
   output logic [7:0]                    o_pd_oe,
   input  wire logic [2:0]               i_pe_in,
   output logic [2:0]                    o_pe_out,
   output logic [2:0]                    o_pe_oe,
   output logic                          o_irq
);
   import psp_pkg::*;

   logic [7:0] out_latch_reg, in_latch_reg, ddir_reg, pe_latch_reg;
   logic [7:0] enab_reg, flags_reg, rdata_reg;
   logic [3:0] ctrl_reg;
   logic       ibf_reg, obf_reg, input_overrun_flag_reg;
   logic [SYNC_STAGES-1:0] s_rd_reg, s_wr_reg, s_cs_reg;
   logic       ext_rd_reg, ext_wr_reg;
   logic [7:0] cap_reg;
   logic [7:0] pd_smp_reg;
   logic [2:0] pe_smp_reg;

   ////////////////////////////////////////////////////////////////////////////
   // Decode
   wire sel     = ctrl_reg[3];
   wire psp_strb_t strb = '{cs_n: i_pe_in[2], wr_n: i_pe_in[1], rd_n: i_pe_in[0]};
   wire w_data  = i_req.wr && i_req.addr == OFS_DATA;
   wire w_cpins = i_req.wr && i_req.addr == OFS_CPINS;
   wire w_flags = i_req.wr && i_req.addr == OFS_FLAGS;
   wire w_ddir  = i_req.wr && i_req.addr == OFS_DDIR;
   wire w_ctrl  = i_req.wr && i_req.addr == OFS_CTRL;
   wire w_enab  = i_req.wr && i_req.addr == OFS_ENAB;
   wire r_data  = i_req.rd && i_req.addr == OFS_DATA;
   wire rd_act  = sel && !s_cs_reg[SYNC_STAGES-1] && !s_rd_reg[SYNC_STAGES-1];
   wire wr_act  = sel && !s_cs_reg[SYNC_STAGES-1] && !s_wr_reg[SYNC_STAGES-1];
   wire rd_done = ext_rd_reg && !rd_act;
   wire wr_done = ext_wr_reg && !wr_act;
   wire cpu_rd_in = r_data && sel;
   wire [7:0] data_rd = sel ? in_latch_reg : pd_smp_reg;
   wire [7:0] ctrl_rd = {ibf_reg, obf_reg, input_overrun_flag_reg, ctrl_reg[3], 1'b0, ctrl_reg[2:0]};
   wire [7:0] rmux =
      (i_req.addr == OFS_DATA)  ? data_rd :
      (i_req.addr == OFS_CPINS) ? {5'h00, pe_smp_reg} :
      (i_req.addr == OFS_FLAGS) ? flags_reg :
      (i_req.addr == OFS_DDIR)  ? ddir_reg :
      (i_req.addr == OFS_CTRL)  ? ctrl_rd :
      (i_req.addr == OFS_ENAB)  ? enab_reg : 8'h00;

   // Data pins driven only by outside read strobe in slave mode
   assign o_pd_out = out_latch_reg;
   assign o_pd_oe  = sel ? {8{rd_act}} : ~ddir_reg;
   assign o_pe_out = pe_latch_reg[2:0];
   assign o_pe_oe  = sel ? 3'h0 : ~ctrl_reg[2:0];
   assign o_rdata  = rdata_reg;
   assign o_irq    = flags_reg[BIT_IRQ] & enab_reg[BIT_IRQ];

   ////////////////////////////////////////////////////////////////////////////
   // Synchronisers and pin sampling
   always_ff @(posedge i_clk or negedge i_arst_n) begin
      if (!i_arst_n) begin
         s_rd_reg   <= '1;
         s_wr_reg   <= '1;
         s_cs_reg   <= '1;
         ext_rd_reg <= 1'b0;
         ext_wr_reg <= 1'b0;
         cap_reg    <= RST_LATCH;
         pd_smp_reg <= RST_LATCH;
         pe_smp_reg <= 3'h0;
      end else begin
         s_rd_reg   <= {s_rd_reg[SYNC_STAGES-2:0], strb.rd_n};
         s_wr_reg   <= {s_wr_reg[SYNC_STAGES-2:0], strb.wr_n};
         s_cs_reg   <= {s_cs_reg[SYNC_STAGES-2:0], strb.cs_n};
         ext_rd_reg <= rd_act;
         ext_wr_reg <= wr_act;
         if (wr_act) begin
            cap_reg <= i_pd_in;
         end
         pd_smp_reg <= i_pd_in;
         pe_smp_reg <= i_pe_in;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // CPU registers and latches
   always_ff @(posedge i_clk or negedge i_arst_n) begin
      if (!i_arst_n) begin
         out_latch_reg <= RST_LATCH;
         pe_latch_reg  <= RST_LATCH;
         ddir_reg      <= RST_DDIR;
         ctrl_reg      <= {RST_CTRL[BIT_SEL], RST_CTRL[2:0]};
         enab_reg      <= RST_ENAB;
         rdata_reg     <= 8'h00;
      end else begin
         if (w_data) begin
            out_latch_reg <= i_req.wdata;
         end
         if (w_cpins) begin
            pe_latch_reg <= i_req.wdata;
         end
         if (w_ddir) begin
            ddir_reg <= i_req.wdata;
         end
         if (w_ctrl) begin
            ctrl_reg <= {i_req.wdata[BIT_SEL], i_req.wdata[2:0]};
         end
         if (w_enab) begin
            enab_reg <= i_req.wdata;
         end
         rdata_reg <= i_req.rd ? rmux : 8'h00;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Status flags; hardware set wins over clear
   always_ff @(posedge i_clk or negedge i_arst_n) begin
      if (!i_arst_n) begin
         ibf_reg      <= 1'b0;
         obf_reg      <= 1'b0;
         input_overrun_flag_reg     <= 1'b0;
         in_latch_reg <= RST_LATCH;
         flags_reg    <= RST_FLAGS;
      end else begin
         if (!sel) begin
            ibf_reg <= 1'b0;
            obf_reg <= 1'b0;
         end else begin
            if (wr_done && (!ibf_reg || cpu_rd_in)) begin
               in_latch_reg <= cap_reg;
            end
            if (wr_done) begin
               ibf_reg <= 1'b1;
            end else if (cpu_rd_in) begin
               ibf_reg <= 1'b0;
            end
            if (w_data) begin
               obf_reg <= 1'b1;
            end else if (rd_done) begin
               obf_reg <= 1'b0;
            end
         end
         if (sel && wr_done && ibf_reg && !cpu_rd_in) begin
            input_overrun_flag_reg <= 1'b1;
         end else if (w_ctrl && !i_req.wdata[BIT_INPUT_OVERRUN_FLAG]) begin
            input_overrun_flag_reg <= 1'b0;
         end
         if (sel && (rd_done || wr_done)) begin
            flags_reg[BIT_IRQ] <= 1'b1;
         end else if (w_flags) begin
            flags_reg[BIT_IRQ] <= i_req.wdata[BIT_IRQ];
         end
         if (w_flags) begin
            flags_reg[BIT_IRQ-1:0] <= {1'b0, i_req.wdata[BIT_IRQ-2:0]};
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Checks
   sequence s_ext_write_end;
      sel && ext_wr_reg && !wr_act;
   endsequence

   a_ibf_on_write: assert property (@(posedge i_clk) disable iff (!i_arst_n)
      s_ext_write_end |=> ibf_reg)
      else $error("input full not set after outside write");
   a_ibf_cpu_clear: assert property (@(posedge i_clk) disable iff (!i_arst_n)
      (cpu_rd_in && !wr_done) |=> !ibf_reg)
      else $error("input full not cleared by cpu read");
   a_obf_on_write: assert property (@(posedge i_clk) disable iff (!i_arst_n)
      (sel && w_data) |=> obf_reg)
      else $error("output full not set by cpu write");
   a_obf_ext_clear: assert property (@(posedge i_clk) disable iff (!i_arst_n)
      (sel && rd_done && !w_data) |=> !obf_reg)
      else $error("output full not cleared by outside read");
   a_ovr_keep_word: assert property (@(posedge i_clk) disable iff (!i_arst_n)
      (s_ext_write_end and ibf_reg && !cpu_rd_in) |=> input_overrun_flag_reg && $stable(in_latch_reg))
      else $error("overrun not flagged or word lost");
   a_full_held_off: assert property (@(posedge i_clk) disable iff (!i_arst_n)
      !sel |=> !ibf_reg && !obf_reg)
      else $error("full flags set outside slave mode");
   a_irq_latched: assert property (@(posedge i_clk) disable iff (!i_arst_n)
      (sel && (rd_done || wr_done)) |=> flags_reg[BIT_IRQ] ##0 (o_irq == enab_reg[BIT_IRQ]))
      else $error("interrupt flag not latched");
   a_pins_follow: assert property (@(posedge i_clk) disable iff (!i_arst_n)
      (sel && !rd_act) |-> o_pd_oe == 8'h00)
      else $error("data pins driven without outside read");
   a_out_latch_load: assert property (@(posedge i_clk) disable iff (!i_arst_n)
      w_data |=> o_pd_out == $past(i_req.wdata))
      else $error("output latch not loaded");
   a_race_word_load: assert property (@(posedge i_clk) disable iff (!i_arst_n)
      (s_ext_write_end and ibf_reg && cpu_rd_in) |=> ibf_reg && in_latch_reg == $past(cap_reg))
      else $error("word lost when cpu read met outside write");
   a_rdata_idle: assert property (@(posedge i_clk) disable iff (!i_arst_n)
      !i_req.rd |=> o_rdata == 8'h00)
      else $error("read data not cleared after read cycle");
endmodule

// [verilog/psp_pkg.sv]
// Package for the parallel slave port: register map, field layout, resets.
// Assumes one 100 MHz clock and a plain address/strobe register port.
//
// Function
// - Setting the slave-port select bit turns the data port into an 8-bit port that an outside master reads and writes.
// - In slave mode control pin 0 is the low-active read strobe, pin 1 the store strobe and pin 2 the chip select.
// - One address holds two 8-bit latches: CPU writes load the output latch and, in slave mode, CPU reads return the input latch.
// - In slave mode the data direction register is ignored and only the outside strobes steer the data pins.
// - The read-only input-full flag sets when an outside word waits and clears when the CPU reads it.
// - The output-full flag sets on a CPU write and clears once the outside master has read the word.
// - A second outside write before the CPU read sets the overrun flag, keeps the first word and drops the new one.
// - Outside slave mode both full flags are held clear while a set overrun flag stays until software clears it.
// - Each finished outside read or write latches the interrupt flag until cleared, and raises a request only if enabled.
// - A CPU port write takes effect at the end of its cycle and a CPU port read samples the pins at its start.
// - The master reads with read strobe and select low, writes with store strobe and select low; high select deselects.
// - Reading a port returns the pin values and writing loads the latch, so read-modify-write writes pin values back.
////////////////////////////////////////////////////////////////////////////////
package psp_pkg;
   localparam int ADDR_W = 8;
   localparam int DATA_W = 8;
   localparam logic [ADDR_W-1:0] OFS_DATA  = 8'h08;
   localparam logic [ADDR_W-1:0] OFS_CPINS = 8'h09;
   localparam logic [ADDR_W-1:0] OFS_FLAGS = 8'h0c;
   localparam logic [ADDR_W-1:0] OFS_DDIR  = 8'h88;
   localparam logic [ADDR_W-1:0] OFS_CTRL  = 8'h89;
   localparam logic [ADDR_W-1:0] OFS_ENAB  = 8'h8c;
   localparam int BIT_IBF   = 7;
   localparam int BIT_OBF   = 6;
   localparam int BIT_INPUT_OVERRUN_FLAG  = 5;
   localparam int BIT_SEL   = 4;
   localparam int BIT_IRQ   = 7;
   localparam logic [7:0] RST_CTRL  = 8'h07;
   localparam logic [7:0] RST_FLAGS = 8'h00;
   localparam logic [7:0] RST_ENAB  = 8'h00;
   localparam logic [7:0] RST_DDIR  = 8'hff;
   localparam logic [7:0] RST_LATCH = 8'h00;
   localparam int SYNC_STAGES = 2;

   typedef struct packed {
      logic                 wr;
      logic                 rd;
      logic [ADDR_W-1:0]    addr;
      logic [DATA_W-1:0]    wdata;
   } psp_req_t;

   typedef struct packed {
      logic       cs_n;
      logic       wr_n;
      logic       rd_n;
   } psp_strb_t;
endpackage

// [verification/psp_ext_master.sv]
// Model of the outside 8-bit master that reads and writes the slave port.
// Assumes the bench resolves the data wire from this model and the port.
`timescale 1ns/1ps
module psp_ext_master (
   input  wire logic       i_clk,
   input  wire logic [7:0] i_pd,
   output logic [7:0]      o_pd,
   output logic [2:0]      o_ctl
);
   initial begin
      o_pd  = 8'h00;
      o_ctl = 3'h7;
   end
   ////////////////////////////////////////////////////////////////////////////
   // One selected strobe, held low 5 cycles; data held 4 cycles past release
   task automatic xfer(input logic wr, input logic [7:0] d, output logic [7:0] q);
      @(posedge i_clk);
      o_ctl <= wr ? 3'h1 : 3'h2;
      if (wr) o_pd <= d;
      repeat (5) @(posedge i_clk);
      q = i_pd;
      o_ctl <= 3'h7;
      repeat (4) @(posedge i_clk);
      o_pd <= ~o_pd;
      repeat (3) @(posedge i_clk);
   endtask
endmodule

// [verification/parallel_slave_port_test.sv]
// Self-checking bench for the parallel slave port.
// Assumes psp_port and the outside master model are compiled first.
`timescale 1ns/1ps
module parallel_slave_port_test;
   import psp_pkg::*;
   logic       i_clk;
   logic       i_arst_n;
   psp_req_t   req;
   logic [7:0] rdata, pd_out, pd_oe, pd_wire, m_pd, q;
   logic [2:0] pe_out, pe_oe, m_ctl;
   logic       irq;
   int         mismatches;
   int         checks;
   assign pd_wire = (pd_oe & pd_out) | (~pd_oe & m_pd);
   psp_port u_psp_port (.i_clk(i_clk), .i_arst_n(i_arst_n), .i_req(req), .o_rdata(rdata),
      .i_pd_in(pd_wire), .o_pd_out(pd_out), .o_pd_oe(pd_oe), .i_pe_in(m_ctl),
      .o_pe_out(pe_out), .o_pe_oe(pe_oe), .o_irq(irq));
   psp_ext_master u_psp_ext_master (.i_clk(i_clk), .i_pd(pd_wire), .o_pd(m_pd), .o_ctl(m_ctl));
   ////////////////////////////////////////////////////////////////////////////
   // Clock, watchdog and tasks
   initial begin
      i_clk = 1'b0;
      forever #5 i_clk = ~i_clk;
   end
   initial begin
      #500000;
      mismatches++;
      end_sim();
   end
   task automatic chk(input logic [7:0] got, input logic [7:0] exp);
      checks++;
      if (got !== exp) begin
         mismatches++;
         $display("[FAIL] t=%0t got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic cpu(input logic w, input logic [7:0] a, input logic [7:0] d);
      @(posedge i_clk);
      req <= '{wr: w, rd: ~w, addr: a, wdata: d};
      @(posedge i_clk);
      req <= '0;
      #1 q = rdata;
   endtask
   task automatic rd(input logic [7:0] a, input logic [7:0] exp);
      cpu(1'b0, a, 8'h00);
      chk(q, exp);
   endtask
   task automatic ext(input logic w, input logic [7:0] d);
      u_psp_ext_master.xfer(w, d, q);
   endtask
   task automatic end_sim;
      $display("checks %0d mismatches %0d", checks, mismatches);
      if (mismatches == 0 && checks > 0) $display("Result: passed");
      else $display("Result: failed");
      $finish;
   endtask
   ////////////////////////////////////////////////////////////////////////////
   // Main sequence
   initial begin
      i_arst_n   = 1'b0;
      req        = '0;
      mismatches = 0;
      checks     = 0;
      repeat (3) @(posedge i_clk);
      i_arst_n <= 1'b1;
      rd(OFS_CTRL, 8'h07);
      rd(OFS_FLAGS, 8'h00);
      rd(OFS_ENAB, 8'h00);
      rd(8'h55, 8'h00);
      cpu(1'b1, OFS_CPINS, 8'h05);
      chk({5'h00, pe_out}, 8'h05);
      cpu(1'b1, OFS_DDIR, 8'h0f);
      cpu(1'b1, OFS_DATA, 8'h3c);
      chk(pd_oe, 8'hf0);
      rd(OFS_CTRL, 8'h07);
      rd(OFS_DATA, 8'h30);
      cpu(1'b1, OFS_CTRL, 8'h17);
      chk({5'h00, pe_oe}, 8'h00);
      cpu(1'b1, OFS_ENAB, 8'h80);
      ext(1'b1, 8'ha5);
      rd(OFS_CTRL, 8'h97);
      chk({7'h00, irq}, 8'h01);
      ext(1'b1, 8'h3c);
      rd(OFS_CTRL, 8'hb7);
      rd(OFS_DATA, 8'ha5);
      rd(OFS_CTRL, 8'h37);
      cpu(1'b1, OFS_FLAGS, 8'h00);
      chk({7'h00, irq}, 8'h00);
      cpu(1'b1, OFS_DATA, 8'h5a);
      rd(OFS_CTRL, 8'h77);
      ext(1'b0, 8'h00);
      chk(q, 8'h5a);
      rd(OFS_CTRL, 8'h37);
      rd(OFS_FLAGS, 8'h80);
      chk({7'h00, irq}, 8'h01);
      cpu(1'b1, OFS_ENAB, 8'h00);
      chk({7'h00, irq}, 8'h00);
      cpu(1'b1, OFS_DATA, 8'h11);
      ext(1'b1, 8'h22);
      cpu(1'b1, OFS_CTRL, 8'h27);
      rd(OFS_CTRL, 8'h27);
      cpu(1'b1, OFS_CTRL, 8'h07);
      rd(OFS_CTRL, 8'h07);
      end_sim();
   end
endmodule
